// File: pmu_pkg.sv
/*
 * Shared constants and types of the controller multiply unit.
 * Assumes a 32-bit classic Wishbone bus with byte addresses.
 */
package pmu_pkg;
    localparam int unsigned ADDR_W      = 6;
    localparam int unsigned WORD_W      = 16;
    localparam int unsigned BIN_HALF_W  = 27;
    localparam int unsigned BIN_W       = 54;
    localparam int unsigned BCD_W       = 64;
    localparam int unsigned DIGITS      = 16;
    localparam int unsigned STACK_DEPTH = 8;
    localparam logic [5:0]  DD_LAST     = 6'h35;

    localparam logic [5:0] OFS_CTRL     = 6'h00;
    localparam logic [5:0] OFS_ACC      = 6'h04;
    localparam logic [5:0] OFS_OPND     = 6'h08;
    localparam logic [5:0] OFS_STACK    = 6'h0C;
    localparam logic [5:0] OFS_FLAGS    = 6'h10;
    localparam logic [5:0] OFS_INT_STAT = 6'h14;
    localparam logic [5:0] OFS_INT_EN   = 6'h18;
    localparam logic [5:0] OFS_INT_CLR  = 6'h1C;
    localparam logic [5:0] OFS_BUSY     = 6'h20;

    localparam int unsigned CB_GO     = 0;
    localparam int unsigned CB_OP     = 1;
    localparam int unsigned CB_SRC    = 3;
    localparam int unsigned CB_RUNG   = 5;
    localparam int unsigned CB_PTR_OK = 6;

    localparam int unsigned INT_W   = 2;
    localparam int unsigned IB_DONE = 0;
    localparam int unsigned IB_ERR  = 1;

    localparam logic [3:0]  BCD_MAX_DIGIT = 4'h9;
    localparam logic [3:0]  DD_ADJ_MIN    = 4'h5;
    localparam logic [3:0]  DD_ADJ        = 4'h3;
    localparam logic [9:0]  FLT_BIAS      = 10'h07F;
    localparam logic [7:0]  FLT_EXP_MAX   = 8'hFF;
    localparam logic [31:0] FLT_QNAN      = 32'h7FC0_0000;

    typedef enum logic [1:0] {
        decimal_multiply_op,
        decimal_double_multiply_op,
        real_multiply_op
    } pmu_op_e;

    typedef enum logic [1:0] {
        PMU_SRC_MEM,
        PMU_SRC_PTR,
        PMU_SRC_CONST
    } pmu_src_e;

    typedef struct packed {
        logic bad_operand_encoding_flag;
        logic float_underflow_flag;
        logic sign_error_flag;
        logic invalid_float_flag;
        logic invalid_pointer_flag;
        logic negative_result_flag;
        logic zero_result_flag;
    } pmu_flags_s;

    typedef struct packed {
        pmu_op_e  op;
        pmu_src_e src;
        logic     rung;
        logic     ptr_ok;
    } pmu_cmd_s;

    typedef struct packed {
        logic [31:0] res;
        logic        uflow;
        logic        ovf;
        logic        nonreal;
        logic        sgn_err;
    } pmu_fres_s;
endpackage

// File: pmu_plc_multiply_unit.sv
/*
 * Accumulator multiply unit: decimal, double decimal and real multiply,
 * status flags, a small accumulator stack and a Wishbone register slave.
 * Assumes one clock, a synchronous reset and software that supplies the
 * operand words and the pointer validity through the registers.
 */
// Local design decisions: the Wishbone register port and the register offsets.
// Overview of operation
// - Decimal multiply takes the low 16 accumulator bits as one factor.
// - Decimal multiply takes a memory word or a four digit constant operand.
// - A decimal product of up to eight digits goes to the accumulator.
// - Double multiply multiplies the eight digit accumulator by two words.
// - Double multiply keeps eight low digits and stacks the high ones.
// - Real multiply multiplies the accumulator float by the operand float.
// - The zero flag is set when the accumulator result is zero.
// - The negative flag is set when the accumulator result is negative.
// - A decimal multiply sets the bad encoding flag on a non-decimal nibble.
// - A real multiply sets the bad encoding flag on a non-real operand.
// - An invalid pointer operand sets the invalid pointer flag.
// - A real multiply leaving an invalid float sets the invalid float flag.
// - A wrong sign bit in the result sets the sign error flag.
// - A real multiply underflow sets the underflow flag.
// - Each flag holds until the next instruction that uses it updates it.
`timescale 1ns/1ps
module pmu_plc_multiply_unit (
    input  wire logic                      clock_i,
    input  wire logic                      rst_i,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [pmu_pkg::ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    output logic                           irq_o
);
    typedef enum logic [1:0] {PMU_IDLE, PMU_CONV, PMU_FIN} pmu_state_e;

    function automatic logic bcd_ok(input logic [31:0] v);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (v[4*i +: 4] > pmu_pkg::BCD_MAX_DIGIT) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    function automatic logic [63:0] bcd2bin(input logic [63:0] v);
        logic [63:0] r;
        r = 64'h0;
        for (int i = pmu_pkg::DIGITS - 1; i >= 0; i--) begin
            r = 64'(r * 64'hA) + {60'h0, v[4*i +: 4]};
        end
        return r;
    endfunction

    function automatic logic [63:0] dd_adjust(input logic [63:0] v);
        logic [63:0] r;
        r = v;
        for (int i = 0; i < pmu_pkg::DIGITS; i++) begin
            if (v[4*i +: 4] >= pmu_pkg::DD_ADJ_MIN) begin
                r[4*i +: 4] = v[4*i +: 4] + pmu_pkg::DD_ADJ;
            end
        end
        return r;
    endfunction

    // Mantissas are truncated and subnormal inputs count as zero; this keeps
    // the datapath to one cycle at the cost of exact IEEE rounding.
    function automatic pmu_pkg::pmu_fres_s fmul(input logic [31:0] a,
                                                input logic [31:0] b);
        pmu_pkg::pmu_fres_s f;
        logic [47:0] m;
        logic [9:0]  e;
        logic        s;
        f = '0;
        s = a[31] ^ b[31];
        m = {1'b1, a[22:0]} * {1'b1, b[22:0]};
        e = {2'h0, a[30:23]} + {2'h0, b[30:23]} - pmu_pkg::FLT_BIAS
            + {9'h0, m[47]};
        f.nonreal = (a[30:23] == pmu_pkg::FLT_EXP_MAX) ||
                    (b[30:23] == pmu_pkg::FLT_EXP_MAX);
        if (f.nonreal) begin
            f.res = pmu_pkg::FLT_QNAN;
        end else if (a[30:23] == 8'h00 || b[30:23] == 8'h00) begin
            f.res = {s, 31'h0};
        end else if (e[9] || e == 10'h000) begin
            f.res   = {s, 31'h0};
            f.uflow = 1'b1;
        end else if (e >= {2'h0, pmu_pkg::FLT_EXP_MAX}) begin
            f.res = {s, pmu_pkg::FLT_EXP_MAX, 23'h0};
            f.ovf = 1'b1;
        end else begin
            f.res = {s, e[7:0], m[47] ? m[46:24] : m[45:23]};
        end
        f.sgn_err = !f.nonreal && (f.res[31] != s);
        return f;
    endfunction

    logic [31:0]         acc_r;
    logic [31:0]         opnd_r;
    logic [31:0]         stack_r [pmu_pkg::STACK_DEPTH];
    pmu_pkg::pmu_flags_s flags_r;
    pmu_pkg::pmu_cmd_s   cmd_r;
    pmu_state_e          state_r;
    logic [5:0]          cnt_r;
    logic [53:0]         bin_r;
    logic [53:0]         prod_r;
    logic [63:0]         bcd_r;
    logic [pmu_pkg::INT_W-1:0] int_stat_r;
    logic [pmu_pkg::INT_W-1:0] int_en_r;

    wire wb_req  = wb_cyc_i && wb_stb_i;
    wire wr_now  = wb_req && wb_we_i && wb_ack_o;
    wire wr_ctrl = wr_now && (wb_adr_i == pmu_pkg::OFS_CTRL);
    wire wr_acc  = wr_now && (wb_adr_i == pmu_pkg::OFS_ACC)
                   && (state_r == PMU_IDLE);
    wire wr_opnd = wr_now && (wb_adr_i == pmu_pkg::OFS_OPND);
    wire wr_pop  = wr_now && (wb_adr_i == pmu_pkg::OFS_STACK)
                   && (state_r == PMU_IDLE);
    wire wr_ien  = wr_now && (wb_adr_i == pmu_pkg::OFS_INT_EN);
    wire wr_iclr = wr_now && (wb_adr_i == pmu_pkg::OFS_INT_CLR);

    pmu_pkg::pmu_cmd_s cmd_w;
    assign cmd_w.op     = pmu_pkg::pmu_op_e'(wb_dat_i[pmu_pkg::CB_OP +: 2]);
    assign cmd_w.src    = pmu_pkg::pmu_src_e'(wb_dat_i[pmu_pkg::CB_SRC +: 2]);
    assign cmd_w.rung   = wb_dat_i[pmu_pkg::CB_RUNG];
    assign cmd_w.ptr_ok = wb_dat_i[pmu_pkg::CB_PTR_OK];

    wire go      = wr_ctrl && wb_dat_i[pmu_pkg::CB_GO]
                   && (state_r == PMU_IDLE);
    wire start   = go && cmd_w.rung;
    wire ptr_bad = (cmd_w.src == pmu_pkg::PMU_SRC_PTR) && !cmd_w.ptr_ok;
    wire is_real = (cmd_w.op == pmu_pkg::real_multiply_op);
    wire is_dbl  = (cmd_w.op == pmu_pkg::decimal_double_multiply_op);

    // A double multiply has no constant form, so its operand is always both
    // words; the single multiply only ever sees the low word.
    wire [31:0] acc_dec = is_dbl ? acc_r : {16'h0, acc_r[15:0]};
    wire [31:0] op_dec  = is_dbl ? opnd_r
                                 : {16'h0, opnd_r[15:0]};
    wire        enc_bad = !bcd_ok(acc_dec) || !bcd_ok(op_dec);
    wire [53:0] prod_w  = 54'(bcd2bin({32'h0, acc_dec})
                          * bcd2bin({32'h0, op_dec}));

    pmu_pkg::pmu_fres_s fr;
    assign fr = fmul(acc_r, opnd_r);

    wire real_ok = start && is_real && !ptr_bad;
    wire dec_go  = start && !is_real && !ptr_bad && !enc_bad;
    wire fin     = (state_r == PMU_FIN);
    // The top bit of the adjusted value is shifted out on purpose: sixteen
    // digits always hold the product, so it is never set.
    wire [63:0] dd_adj = dd_adjust(bcd_r);
    wire [63:0] dd_nxt = {dd_adj[62:0], bin_r[53]};

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_r <= PMU_IDLE;
            cnt_r   <= 6'h00;
        end else begin
            case (state_r)
                PMU_IDLE: begin
                    if (dec_go) begin
                        state_r <= PMU_CONV;
                    end
                    cnt_r <= 6'h00;
                end
                PMU_CONV: begin
                    if (cnt_r == pmu_pkg::DD_LAST) begin
                        state_r <= PMU_FIN;
                    end
                    cnt_r <= cnt_r + 6'h01;
                end
                default: begin
                    state_r <= PMU_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (dec_go) begin
            bin_r  <= prod_w;
            prod_r <= prod_w;
            bcd_r  <= 64'h0;
        end else if (state_r == PMU_CONV) begin
            bin_r <= {bin_r[52:0], 1'b0};
            bcd_r <= dd_nxt[63:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            acc_r  <= 32'h0;
            opnd_r <= 32'h0;
            cmd_r  <= '0;
        end else begin
            if (wr_acc) begin
                acc_r <= wb_dat_i;
            end else if (real_ok) begin
                acc_r <= fr.res;
            end else if (fin) begin
                acc_r <= bcd_r[31:0];
            end
            if (wr_opnd) begin
                opnd_r <= wb_dat_i;
            end
            if (go) begin
                cmd_r <= cmd_w;
            end
        end
    end

    // The stack shifts as a whole; a push past the last entry drops it.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            for (int i = 0; i < pmu_pkg::STACK_DEPTH; i++) begin
                stack_r[i] <= 32'h0;
            end
        end else if (fin && cmd_r.op == pmu_pkg::decimal_double_multiply_op)
        begin
            stack_r[0] <= bcd_r[63:32];
            for (int i = 1; i < pmu_pkg::STACK_DEPTH; i++) begin
                stack_r[i] <= stack_r[i-1];
            end
        end else if (wr_pop) begin
            for (int i = 0; i < pmu_pkg::STACK_DEPTH - 1; i++) begin
                stack_r[i] <= stack_r[i+1];
            end
            stack_r[pmu_pkg::STACK_DEPTH-1] <= 32'h0;
        end
    end

    // Only flags that an instruction uses are touched by it.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            flags_r <= '0;
        end else if (start) begin
            flags_r.invalid_pointer_flag <= ptr_bad;
            if (is_real && !ptr_bad) begin
                flags_r.bad_operand_encoding_flag <= fr.nonreal;
                flags_r.float_underflow_flag <= fr.uflow;
                flags_r.sign_error_flag <= fr.sgn_err;
                flags_r.invalid_float_flag <=
                    fr.nonreal || fr.ovf;
                flags_r.zero_result_flag <=
                    (fr.res[30:0] == 31'h0);
                flags_r.negative_result_flag <= fr.res[31];
            end else if (!is_real && !ptr_bad) begin
                flags_r.bad_operand_encoding_flag <= enc_bad;
            end
        end else if (fin) begin
            flags_r.zero_result_flag <= (bcd_r[31:0] == 32'h0);
            flags_r.negative_result_flag <= bcd_r[31];
        end
    end

    wire [pmu_pkg::INT_W-1:0] int_evt;
    assign int_evt[pmu_pkg::IB_DONE] = real_ok || fin;
    assign int_evt[pmu_pkg::IB_ERR]  = start && (ptr_bad || (is_real
                                       ? (fr.nonreal || fr.ovf || fr.uflow)
                                       : enc_bad));

    // A new event wins over a clear in the same cycle.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            int_stat_r <= '0;
            int_en_r   <= '0;
            irq_o      <= 1'b0;
        end else begin
            int_stat_r <= (int_stat_r & ~(wr_iclr
                          ? wb_dat_i[pmu_pkg::INT_W-1:0] : '0)) | int_evt;
            if (wr_ien) begin
                int_en_r <= wb_dat_i[pmu_pkg::INT_W-1:0];
            end
            irq_o <= |(int_stat_r & int_en_r);
        end
    end

    wire [31:0] rd_mux =
        (wb_adr_i == pmu_pkg::OFS_CTRL)     ? {25'h0, cmd_r.ptr_ok,
                                               cmd_r.rung, cmd_r.src,
                                               cmd_r.op, 1'b0} :
        (wb_adr_i == pmu_pkg::OFS_ACC)      ? acc_r :
        (wb_adr_i == pmu_pkg::OFS_OPND)     ? opnd_r :
        (wb_adr_i == pmu_pkg::OFS_STACK)    ? stack_r[0] :
        (wb_adr_i == pmu_pkg::OFS_FLAGS)    ? {25'h0, flags_r} :
        (wb_adr_i == pmu_pkg::OFS_INT_STAT) ? {30'h0, int_stat_r} :
        (wb_adr_i == pmu_pkg::OFS_INT_EN)   ? {30'h0, int_en_r} :
        (wb_adr_i == pmu_pkg::OFS_BUSY)     ? {31'h0, state_r != PMU_IDLE} :
                                              32'h0;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_req && !wb_ack_o;
            wb_dat_o <= rd_mux;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence s_dec_launch;
        dec_go ##1 (state_r == PMU_CONV);
    endsequence

    a_rung_hold: assert property (go && !cmd_w.rung |=>
        $stable(acc_r) && $stable(flags_r) && state_r == PMU_IDLE)
        else $error("multiply ran with a false rung");
    a_low_word_op: assert property (dec_go && !is_dbl |=>
        prod_r == 54'(bcd2bin({48'h0, $past(acc_r[15:0])})
                      * bcd2bin({48'h0, $past(opnd_r[15:0])})))
        else $error("decimal multiply used wrong operands");
    a_conv_len: assert property (s_dec_launch |->
        ##53 (state_r == PMU_CONV) ##1 fin)
        else $error("conversion length wrong");
    a_dd_result: assert property (fin |->
        bcd2bin(bcd_r) == {10'h0, prod_r})
        else $error("decimal product wrong");
    a_push_high: assert property (fin && !wr_acc && cmd_r.op ==
        pmu_pkg::decimal_double_multiply_op |=>
        stack_r[0] == $past(bcd_r[63:32]) && acc_r == $past(bcd_r[31:0]))
        else $error("double multiply result not split");
    a_real_acc: assert property (real_ok && !wr_acc |=>
        acc_r == $past(fr.res))
        else $error("real product not in accumulator");
    a_zero_flag: assert property (fin |=>
        flags_r.zero_result_flag == (acc_r == 32'h0))
        else $error("zero flag wrong");
    a_neg_flag: assert property ((fin || real_ok) && !wr_acc |=>
        flags_r.negative_result_flag == acc_r[31])
        else $error("negative flag wrong");
    a_bad_bcd: assert property (start && !is_real && enc_bad
        && !ptr_bad |=> flags_r.bad_operand_encoding_flag
        && state_r == PMU_IDLE)
        else $error("bad digit not flagged");
    a_ptr_flag: assert property (start |=>
        flags_r.invalid_pointer_flag == $past(ptr_bad))
        else $error("pointer flag wrong");
    a_uflow_flag: assert property (real_ok |=>
        flags_r.float_underflow_flag == $past(fr.uflow)
        && flags_r.invalid_float_flag == $past(fr.nonreal || fr.ovf))
        else $error("float flags wrong");
endmodule

// File: pmu_testbench.sv
/*
 * Self-checking testbench of the accumulator multiply unit.
 * Assumes the unit answers over classic Wishbone on a single 125 MHz clock.
 */
`timescale 1ns/1ps
module testbench;
    logic                        clock_i;
    logic                        rst_i;
    logic                        wb_cyc_i;
    logic                        wb_stb_i;
    logic                        wb_we_i;
    logic [pmu_pkg::ADDR_W-1:0]  wb_adr_i;
    logic [3:0]                  wb_sel_i;
    logic [31:0]                 wb_dat_i;
    logic [31:0]                 wb_dat_o;
    logic                        wb_ack_o;
    logic                        irq_o;
    logic [31:0]                 rd;
    int                          n_fail;
    int                          checks;

    pmu_plc_multiply_unit u_dut (
        .clock_i  (clock_i),
        .rst_i    (rst_i),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_dat_i (wb_dat_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .irq_o    (irq_o)
    );

    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    task automatic close_out();
        if (n_fail == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // The run is under a thousand cycles; this limit leaves a wide margin.
    initial begin
        #400000;
        n_fail++;
        close_out();
    end

    task automatic cmp(input string what, input logic [31:0] exp,
                       input logic [31:0] got, input logic [31:0] mask);
        checks++;
        if ((got & mask) !== (exp & mask)) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One classic cycle; the request stands until ack is sampled high.
    task automatic wb(input logic we, input logic [5:0] adr,
                      input logic [31:0] dat);
        int n;
        @(posedge clock_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'hF;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_fail++;
            close_out();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic rd_cmp(input string what, input logic [5:0] adr,
                          input logic [31:0] exp, input logic [31:0] mask);
        wb(1'b0, adr, 32'h0);
        cmp(what, exp, rd, mask);
    endtask

    // Loads both factors, starts the operation and polls until idle.
    task automatic run(input pmu_pkg::pmu_op_e op,
                       input pmu_pkg::pmu_src_e src,
                       input logic rung, input logic ptr,
                       input logic [31:0] acc, input logic [31:0] opnd);
        int n;
        logic [31:0] c;
        c = 32'h1 | (32'(op) << pmu_pkg::CB_OP)
            | (32'(src) << pmu_pkg::CB_SRC)
            | (32'(rung) << pmu_pkg::CB_RUNG)
            | (32'(ptr) << pmu_pkg::CB_PTR_OK);
        wb(1'b1, pmu_pkg::OFS_ACC, acc);
        wb(1'b1, pmu_pkg::OFS_OPND, opnd);
        wb(1'b1, pmu_pkg::OFS_CTRL, c);
        n = 0;
        do begin
            wb(1'b0, pmu_pkg::OFS_BUSY, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 100);
        if (n >= 100) begin
            n_fail++;
            close_out();
        end
    endtask

    task automatic res(input logic [31:0] acc, input logic [31:0] fl,
                       input logic [31:0] amask, input logic [31:0] fmask);
        rd_cmp("accumulator", pmu_pkg::OFS_ACC, acc, amask);
        rd_cmp("flags", pmu_pkg::OFS_FLAGS, fl, fmask);
    endtask

    task automatic t_reset();
        rd_cmp("acc", pmu_pkg::OFS_ACC, 32'h0, 32'hFFFFFFFF);
        rd_cmp("flags", pmu_pkg::OFS_FLAGS, 32'h0, 32'hFFFFFFFF);
        rd_cmp("stack", pmu_pkg::OFS_STACK, 32'h0, 32'hFFFFFFFF);
        rd_cmp("int stat", pmu_pkg::OFS_INT_STAT, 32'h0, 32'hFFFFFFFF);
        rd_cmp("busy", pmu_pkg::OFS_BUSY, 32'h0, 32'hFFFFFFFF);
        rd_cmp("unmapped", 6'h24, 32'h0, 32'hFFFFFFFF);
        cmp("irq", 32'h0, {31'h0, irq_o}, 32'h1);
    endtask

    task automatic t_decimal();
        run(pmu_pkg::decimal_multiply_op, pmu_pkg::PMU_SRC_MEM, 1'b1, 1'b1,
            32'h5555_1234, 32'h0000_0002);
        res(32'h0000_2468, 32'h00, 32'hFFFFFFFF, 32'h7F);
        run(pmu_pkg::decimal_multiply_op, pmu_pkg::PMU_SRC_CONST, 1'b1, 1'b1,
            32'h0000_9999, 32'h0000_9999);
        res(32'h9998_0001, 32'h02, 32'hFFFFFFFF, 32'h7F);
        run(pmu_pkg::decimal_multiply_op, pmu_pkg::PMU_SRC_MEM, 1'b1, 1'b1,
            32'h0000_1234, 32'h0000_0000);
        res(32'h0, 32'h01, 32'hFFFFFFFF, 32'h7F);
    endtask

    task automatic t_double();
        run(pmu_pkg::decimal_double_multiply_op, pmu_pkg::PMU_SRC_MEM, 1'b1,
            1'b1, 32'h1234_5678, 32'h0000_0002);
        res(32'h2469_1356, 32'h00, 32'hFFFFFFFF, 32'h7F);
        rd_cmp("stack", pmu_pkg::OFS_STACK, 32'h0, 32'hFFFFFFFF);
        run(pmu_pkg::decimal_double_multiply_op, pmu_pkg::PMU_SRC_MEM, 1'b1,
            1'b1, 32'h9999_9999, 32'h0000_0003);
        res(32'h9999_9997, 32'h02, 32'hFFFFFFFF, 32'h7F);
        rd_cmp("stack", pmu_pkg::OFS_STACK, 32'h2, 32'hFFFFFFFF);
    endtask

    // A product whose low eight digits would be zero proves the rung gate holds the accumulator, flags and stack.
    task automatic t_rung();
        run(pmu_pkg::decimal_double_multiply_op, pmu_pkg::PMU_SRC_MEM, 1'b0,
            1'b1, 32'h5000_0000, 32'h0000_0004);
        res(32'h5000_0000, 32'h02, 32'hFFFFFFFF, 32'h7F);
        rd_cmp("stack", pmu_pkg::OFS_STACK, 32'h2, 32'hFFFFFFFF);
        rd_cmp("ctrl", pmu_pkg::OFS_CTRL, 32'h42, 32'hFFFFFFFF);
        wb(1'b1, pmu_pkg::OFS_STACK, 32'h0);
        rd_cmp("pop", pmu_pkg::OFS_STACK, 32'h0, 32'hFFFFFFFF);
    endtask

    task automatic t_bad();
        run(pmu_pkg::decimal_multiply_op, pmu_pkg::PMU_SRC_MEM, 1'b1, 1'b1,
            32'h0000_1234, 32'h0000_000A);
        res(32'h0000_1234, 32'h40, 32'hFFFFFFFF, 32'h40);
        run(pmu_pkg::decimal_multiply_op, pmu_pkg::PMU_SRC_MEM, 1'b1, 1'b1,
            32'h0000_0001, 32'h0000_0003);
        res(32'h0000_0003, 32'h00, 32'hFFFFFFFF, 32'h7F);
    endtask

    task automatic t_real();
        run(pmu_pkg::real_multiply_op, pmu_pkg::PMU_SRC_PTR, 1'b1, 1'b1,
            32'h4000_0000, 32'h4040_0000);
        res(32'h40C0_0000, 32'h00, 32'hFFFFFFFF, 32'h7F);
        run(pmu_pkg::real_multiply_op, pmu_pkg::PMU_SRC_CONST, 1'b1, 1'b1,
            32'hC000_0000, 32'h4040_0000);
        res(32'hC0C0_0000, 32'h02, 32'hFFFFFFFF, 32'h7F);
        run(pmu_pkg::real_multiply_op, pmu_pkg::PMU_SRC_MEM, 1'b1, 1'b1,
            32'h3F80_0000, 32'h7FC0_0000);
        res(32'h7FC0_0000, 32'h48, 32'hFFFFFFFF, 32'h48);
        run(pmu_pkg::real_multiply_op, pmu_pkg::PMU_SRC_MEM, 1'b1, 1'b1,
            32'h0080_0000, 32'h0080_0000);
        res(32'h0000_0000, 32'h21, 32'hFFFFFFFF, 32'h21);
        run(pmu_pkg::real_multiply_op, pmu_pkg::PMU_SRC_MEM, 1'b1, 1'b1,
            32'h7F00_0000, 32'h7F00_0000);
        res(32'h7F80_0000, 32'h08, 32'hFFFFFFFF, 32'h08);
        run(pmu_pkg::real_multiply_op, pmu_pkg::PMU_SRC_PTR, 1'b1, 1'b0,
            32'h4000_0000, 32'h4040_0000);
        res(32'h4000_0000, 32'h04, 32'hFFFFFFFF, 32'h04);
    endtask

    // The interrupt lags status by a cycle, so it is sampled two edges on.
    task automatic t_irq();
        wb(1'b1, pmu_pkg::OFS_INT_CLR, 32'h3);
        wb(1'b1, pmu_pkg::OFS_INT_EN, 32'h1);
        run(pmu_pkg::decimal_multiply_op, pmu_pkg::PMU_SRC_MEM, 1'b1, 1'b1,
            32'h0000_0011, 32'h0000_0002);
        rd_cmp("int stat", pmu_pkg::OFS_INT_STAT, 32'h1, 32'h1);
        cmp("irq", 32'h1, {31'h0, irq_o}, 32'h1);
        wb(1'b1, pmu_pkg::OFS_INT_CLR, 32'h1);
        repeat (2) @(posedge clock_i);
        cmp("irq", 32'h0, {31'h0, irq_o}, 32'h1);
        wb(1'b1, pmu_pkg::OFS_INT_EN, 32'h2);
        run(pmu_pkg::decimal_multiply_op, pmu_pkg::PMU_SRC_MEM, 1'b1, 1'b1,
            32'h0000_0011, 32'h0000_00B0);
        rd_cmp("int stat", pmu_pkg::OFS_INT_STAT, 32'h2, 32'h2);
        cmp("irq", 32'h1, {31'h0, irq_o}, 32'h1);
        wb(1'b1, pmu_pkg::OFS_INT_EN, 32'h0);
        repeat (2) @(posedge clock_i);
        cmp("irq masked", 32'h0, {31'h0, irq_o}, 32'h1);
        wb(1'b1, pmu_pkg::OFS_INT_CLR, 32'h3);
        rd_cmp("int stat", pmu_pkg::OFS_INT_STAT, 32'h0, 32'hFFFFFFFF);
    endtask

    initial begin
        n_fail   = 0;
        checks   = 0;
        rst_i    = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i  = 1'b0;
        wb_adr_i = '0;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        t_reset();
        t_decimal();
        t_double();
        t_rung();
        t_bad();
        t_real();
        t_irq();
        close_out();
    end
endmodule
